/* src/telecom_bus_line_input_select.sv */
// shared pin steering between telecom bus inputs and line interface receive inputs
//
// Summary of operation
// - bus enabled: pin is parity, else positive data
// - parity always covers the eight data bits
// - parity option adds payload and frame marker
// - coverage and sense set at 0x0139
// - positive data sampled on selected clock edge
// - alarm pulse declares path AIS defect
// - alarm pin role follows line mode
// - single rail: pin counts line code violations
`timescale 1ns/1ps
module telecom_bus_line_input_select
    import line_sel_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_srst,
    // register port
    input  wire logic [15:0]           i_reg_addr,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    input  wire logic [7:0]            i_reg_wdata,
    output logic      [7:0]            o_reg_rdata,
    // shared pins
    input  wire logic                  i_line_rx_clock,
    input  wire logic [7:0]            i_bus_data_in,
    input  wire logic                  i_payload_indicator_in,
    input  wire logic                  i_frame_marker_in,
    input  wire logic                  i_bus_parity_in,
    input  wire logic                  i_bus_alarm_in,
    // received stream
    output logic                       o_rx_valid,
    output logic      [FIFO_WIDTH-1:0] o_rx_data,
    input  wire logic                  i_rx_ready,
    // events and state
    output logic                       o_parity_err,
    output logic                       o_lcv_event,
    output logic                       o_path_ais
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  ck1;
        logic                  ck2;
        logic                  ck3;
        logic [11:0]           pin1;
        logic [11:0]           pin2;
        logic [7:0]            ctl_r;
        logic                  perr_r;
        logic                  ais_r;
        logic                  ovf_r;
        logic [7:0]            lcv_cnt_r;
        logic                  parity_err_r;
        logic                  lcv_ev_r;
        logic [7:0]            rdata_r;
        logic                  out_valid_r;
        logic [FIFO_WIDTH-1:0] out_data_r;
    } sel_s;

    sel_s        q;
    sel_s        n;
    logic        strobe;
    logic        bus_en;
    logic        par_all;
    logic        par_odd;
    logic        edge_fall;
    line_mode_e  mode;
    logic [7:0]  d;
    logic        pl;
    logic        fm;
    logic        par;
    logic        alm;
    logic        par_exp;
    logic        wr_sts;
    logic [7:0]  clr;

    stream_if #(.W(FIFO_WIDTH)) push_if ();
    stream_if #(.W(FIFO_WIDTH)) pop_if ();

    stream_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .push      (push_if.snk),
        .pop       (pop_if.src)
    );

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    assign bus_en    = q.ctl_r[CTL_BUS_EN_BIT];
    assign par_all   = q.ctl_r[CTL_PAR_ALL_BIT];
    assign par_odd   = q.ctl_r[CTL_PAR_ODD_BIT];
    assign edge_fall = q.ctl_r[CTL_EDGE_FALL_BIT];
    assign mode      = line_mode_e'(q.ctl_r[CTL_MODE_LSB +: 2]);
    assign d         = q.pin2[11:4];
    assign pl        = q.pin2[3];
    assign fm        = q.pin2[2];
    assign par       = q.pin2[1];
    assign alm       = q.pin2[0];
    // link clock edge found two flops after the pin
    assign strobe    = edge_fall ? (q.ck3 && !q.ck2) : (q.ck2 && !q.ck3);
    assign par_exp   = (^d) ^ (par_all & (pl ^ fm)) ^ par_odd;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n              = q;
        push_if.valid  = 1'b0;
        push_if.data   = '0;
        pop_if.ready   = !q.out_valid_r || i_rx_ready;
        wr_sts         = i_reg_wr && (i_reg_addr == STATUS_ADDR);
        clr            = wr_sts ? i_reg_wdata : 8'h00;
        n.ck1          = i_line_rx_clock;
        n.ck2          = q.ck1;
        n.ck3          = q.ck2;
        n.pin1         = {i_bus_data_in, i_payload_indicator_in, i_frame_marker_in,
                          i_bus_parity_in, i_bus_alarm_in};
        n.pin2         = q.pin1;
        n.parity_err_r = 1'b0;
        n.lcv_ev_r     = 1'b0;
        n.perr_r       = q.perr_r & ~clr[STS_PERR_BIT];
        n.ais_r        = q.ais_r & ~clr[STS_AIS_BIT];
        n.ovf_r        = q.ovf_r & ~clr[STS_OVF_BIT];
        if (i_reg_wr && (i_reg_addr == ICTL2_ADDR)) begin
            n.ctl_r = i_reg_wdata;
        end
        if (strobe) begin
            push_if.valid = 1'b1;
            if (bus_en) begin
                push_if.data = {pl, fm, d};
                if (par != par_exp) begin
                    n.parity_err_r = 1'b1;
                    n.perr_r       = 1'b1;
                end
                if (alm) begin
                    n.ais_r = 1'b1;
                end
            end else begin
                // positive pin carries all data or its positive part
                push_if.data[1] = par;
                case (mode)
                    MODE_DS3_DUAL: begin
                        push_if.data[0] = alm;
                    end
                    MODE_DS3_SINGLE: begin
                        n.lcv_ev_r = alm;
                        if (alm && (q.lcv_cnt_r != LCV_MAX)) begin
                            n.lcv_cnt_r = q.lcv_cnt_r + 8'h01;
                        end
                    end
                    default: begin
                        // pin is grounded in sts-1 mode, so it is simply ignored
                        push_if.data[0] = 1'b0;
                    end
                endcase
            end
            // the pins cannot be stalled; a full buffer loses the sample
            if (!push_if.ready) begin
                n.ovf_r = 1'b1;
            end
        end
        if (q.out_valid_r && i_rx_ready) begin
            n.out_valid_r = 1'b0;
        end
        if (pop_if.valid && pop_if.ready) begin
            n.out_valid_r = 1'b1;
            n.out_data_r  = pop_if.data;
        end
        if (i_reg_rd) begin
            if (i_reg_addr == ICTL2_ADDR) begin
                n.rdata_r = q.ctl_r;
            end else if (i_reg_addr == STATUS_ADDR) begin
                n.rdata_r = {5'h00, q.ovf_r, q.ais_r, q.perr_r};
            end else if (i_reg_addr == LCV_COUNT_ADDR) begin
                n.rdata_r = q.lcv_cnt_r;
            end else begin
                n.rdata_r = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            q           <= '0;
            q.ctl_r     <= CTL_RESET;
            q.lcv_cnt_r <= LCV_RESET;
        end else begin
            q <= n;
        end
    end

    assign o_reg_rdata  = q.rdata_r;
    assign o_rx_valid   = q.out_valid_r;
    assign o_rx_data    = q.out_data_r;
    assign o_parity_err = q.parity_err_r;
    assign o_lcv_event  = q.lcv_ev_r;
    assign o_path_ais   = q.ais_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    sequence s_alarm_seen;
        strobe && bus_en && alm;
    endsequence

    sequence s_no_clear;
        !(wr_sts && i_reg_wdata[STS_AIS_BIT]) [*2];
    endsequence

    AST_CTL_WRITE: assert property (
        i_reg_wr && (i_reg_addr == ICTL2_ADDR) |=> q.ctl_r == $past(i_reg_wdata))
        else $error("control byte not stored");
    AST_PAR_DATA_ONLY: assert property (
        strobe && bus_en && !par_all |=> o_parity_err == $past((^d) ^ par_odd ^ par))
        else $error("data-only parity check wrong");
    AST_PAR_ALL: assert property (
        strobe && bus_en && par_all |=> o_parity_err == $past((^d) ^ pl ^ fm ^ par_odd ^ par))
        else $error("full parity check wrong");
    AST_PERR_STICKY: assert property (
        o_parity_err |-> q.perr_r)
        else $error("parity error not recorded");
    AST_AIS_DECLARE: assert property (
        s_alarm_seen ##0 s_no_clear |-> o_path_ais ##1 o_path_ais)
        else $error("path ais not declared");
    AST_POS_SAMPLE: assert property (
        strobe && !bus_en |-> push_if.valid && (push_if.data[1] == par) && !n.parity_err_r)
        else $error("positive data not taken");
    AST_EDGE_SELECT: assert property (
        $rose(i_line_rx_clock) && !edge_fall && !i_reg_wr ##1 !i_reg_wr |-> ##1 strobe)
        else $error("rising edge not used");
    AST_LCV_COUNT: assert property (
        strobe && !bus_en && (mode == MODE_DS3_SINGLE) && alm && (q.lcv_cnt_r != LCV_MAX)
        |=> o_lcv_event && (q.lcv_cnt_r == $past(q.lcv_cnt_r) + 8'h01))
        else $error("line code violation not counted");
    AST_NEG_ROLE: assert property (
        strobe && !bus_en |-> push_if.data[0] == ((mode == MODE_DS3_DUAL) ? alm : 1'b0))
        else $error("negative pin role wrong");
endmodule // telecom_bus_line_input_select

/* src/line_sel_pkg.sv */
// constants, field layout and types shared by the line input select block
package line_sel_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ICTL2_ADDR      = 16'h0139;
    localparam logic [15:0] STATUS_ADDR     = 16'h0140;
    localparam logic [15:0] LCV_COUNT_ADDR  = 16'h0141;

    // ------------------------------------------------------------
    // interface control fields and reset values
    // ------------------------------------------------------------
    localparam int          CTL_BUS_EN_BIT    = 0;
    localparam int          CTL_PAR_ALL_BIT   = 1;
    localparam int          CTL_PAR_ODD_BIT   = 2;
    localparam int          CTL_EDGE_FALL_BIT = 3;
    localparam int          CTL_MODE_LSB      = 4;
    localparam logic [7:0]  CTL_RESET         = 8'h00;

    // ------------------------------------------------------------
    // status fields, write one to clear
    // ------------------------------------------------------------
    localparam int          STS_PERR_BIT = 0;
    localparam int          STS_AIS_BIT  = 1;
    localparam int          STS_OVF_BIT  = 2;
    localparam logic [7:0]  LCV_RESET    = 8'h00;
    localparam logic [7:0]  LCV_MAX      = 8'hFF;

    // ------------------------------------------------------------
    // stream buffer shape
    // ------------------------------------------------------------
    localparam int          FIFO_WIDTH = 10;
    localparam int          FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        MODE_STS1,
        MODE_DS3_SINGLE,
        MODE_DS3_DUAL,
        MODE_RESERVED
    } line_mode_e;

endpackage

/* src/stream_if.sv */
// valid/ready carrier between the selector and its buffer
`timescale 1ns/1ps
interface stream_if #(parameter int W = 10);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* src/stream_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // fill and drain sides
    stream_if.snk    push,
    stream_if.src    pop
);
    localparam int             AW   = $clog2(DEPTH);
    localparam logic [AW:0]    FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_s;

    fifo_s q;
    fifo_s n;
    logic  do_push;
    logic  do_pop;

    assign push.ready = (q.cnt != FULL);
    assign pop.valid  = (q.cnt != '0);
    assign pop.data   = q.mem[q.rd];

    always_comb begin
        n       = q;
        do_push = push.valid && push.ready;
        do_pop  = pop.valid && pop.ready;
        if (do_push) begin
            n.mem[q.wr] = push.data;
            n.wr        = q.wr + 1'b1;
        end
        if (do_pop) begin
            n.rd = q.rd + 1'b1;
        end
        if (do_push && !do_pop) begin
            n.cnt = q.cnt + 1'b1;
        end else if (!do_push && do_pop) begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule // stream_fifo

/* tb/line_partner_model.sv */
// behavioural line interface unit and telecom bus source for the input select block
`timescale 1ns/1ps
module line_partner_model (
    // board strap for the shared negative pin
    input  wire logic       i_hold_neg_low,
    // pins toward the device
    output logic            o_link_clk,
    output logic            o_par_pos,
    output logic            o_alarm_neg,
    output logic [7:0]      o_data,
    output logic            o_pl,
    output logic            o_fm
);
    // ------------------------------------------------------------
    // one link clock period per call
    // ------------------------------------------------------------
    // the clock stands low between calls; lines flip between the edges,
    // so a falling edge sample sees the inverse and stale data never matches
    initial begin
        o_link_clk  = 1'h0;
        o_par_pos   = 1'h0;
        o_alarm_neg = 1'h0;
        o_data      = 8'h00;
        o_pl        = 1'h0;
        o_fm        = 1'h0;
    end

    task automatic send(input logic p, input logic n, input logic [7:0] d,
                        input logic l, input logic f);
        o_par_pos   = p;
        o_alarm_neg = n & ~i_hold_neg_low;
        o_data      = d;
        o_pl        = l;
        o_fm        = f;
        #50 o_link_clk = 1'h1;
        #50;
        o_par_pos   = ~o_par_pos;
        o_alarm_neg = ~o_alarm_neg & ~i_hold_neg_low;
        o_data      = ~o_data;
        o_pl        = ~o_pl;
        o_fm        = ~o_fm;
        #50 o_link_clk = 1'h0;
        #50;
    endtask
endmodule // line_partner_model

/* tb/tb_top.sv */
// self-checking bench for the line input select block
`timescale 1ns/1ps
module tb_top;
    import line_sel_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                  clk_sys = 1'h0;
    logic                  srst = 1'h1;
    logic [15:0]           reg_addr = 16'h0000;
    logic                  reg_wr = 1'h0;
    logic                  reg_rd = 1'h0;
    logic [7:0]            reg_wdata = 8'h00;
    logic [7:0]            reg_rdata;
    logic                  link_clk, pl, fm, par_pos, alarm_neg;
    logic [7:0]            bus_data;
    logic                  rx_valid;
    logic [FIFO_WIDTH-1:0] rx_data;
    logic                  rx_ready = 1'h1;
    logic                  parity_err, lcv_event, path_ais;
    logic                  hold_neg_low = 1'h0;
    logic [FIFO_WIDTH-1:0] words[$];
    int                    perr_n = 0;
    int                    lcv_n = 0;
    int                    miscompares = 0;
    int                    checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    telecom_bus_line_input_select i_telecom_bus_line_input_select (
        .i_clk_sys(clk_sys), .i_srst(srst), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
        .i_line_rx_clock(link_clk), .i_bus_data_in(bus_data), .i_payload_indicator_in(pl),
        .i_frame_marker_in(fm), .i_bus_parity_in(par_pos), .i_bus_alarm_in(alarm_neg),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready),
        .o_parity_err(parity_err), .o_lcv_event(lcv_event), .o_path_ais(path_ais));

    line_partner_model i_line_partner_model (
        .i_hold_neg_low(hold_neg_low), .o_link_clk(link_clk), .o_par_pos(par_pos),
        .o_alarm_neg(alarm_neg), .o_data(bus_data), .o_pl(pl), .o_fm(fm));

    // ------------------------------------------------------------
    // monitors and tasks
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rx_valid === 1'h1 && rx_ready === 1'h1) begin
            words.push_back(rx_data);
        end
        perr_n <= perr_n + int'(parity_err === 1'h1);
        lcv_n  <= lcv_n + int'(lcv_event === 1'h1);
    end

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'h0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'h0;
        @(posedge clk_sys);
        #1;
        check($sformatf("reg %h", a), {2'h0, reg_rdata}, {2'h0, exp});
    endtask

    task automatic wait_n(input int n);
        int k;
        k = 0;
        while (words.size() < n && k < 60) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (words.size() < n) begin
            miscompares++;
            print_verdict();
        end
    endtask

    task automatic get(input logic [9:0] exp);
        wait_n(1);
        check("rx word", words.pop_front(), exp);
    endtask

    // payload and frame marker always differ, so full coverage adds one
    task automatic tx(input logic p, input logic n, input logic [7:0] d);
        // pin edges land on falling system edges, away from the sampling edge
        @(negedge clk_sys);
        i_line_partner_model.send(p, n, d, ~d[0], d[0]);
    endtask

    function automatic logic par(logic [7:0] d, logic all, logic odd);
        return ^d ^ all ^ odd;
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        int         p0;
        repeat (3) @(posedge clk_sys);
        srst <= 1'h0;
        repeat (3) @(posedge clk_sys);
        rdc(ICTL2_ADDR, CTL_RESET);
        rdc(LCV_COUNT_ADDR, LCV_RESET);
        wr(16'h0200, 8'hFF);
        rdc(16'h0200, 8'h00);
        wr(LCV_COUNT_ADDR, 8'h55);
        rdc(LCV_COUNT_ADDR, LCV_RESET);
        wr(ICTL2_ADDR, 8'hC5);
        rdc(ICTL2_ADDR, 8'hC5);
        for (int c = 0; c < 4; c++) begin
            d = 8'h3C ^ 8'(c);
            wr(ICTL2_ADDR, 8'h01 | 8'(c << 1));
            p0 = perr_n;
            tx(par(d, c[0], c[1]), 1'h0, d);
            get({~d[0], d[0], d});
            tx(~par(d, c[0], c[1]), 1'h0, d);
            get({~d[0], d[0], d});
            check("parity errors", 10'(perr_n - p0), 10'h001);
        end
        rdc(STATUS_ADDR, 8'h01);
        wr(STATUS_ADDR, 8'h01);
        #1;
        check("path ais", {9'h000, path_ais}, 10'h000);
        tx(par(8'h5A, 1'h1, 1'h1), 1'h1, 8'h5A);
        get({2'h2, 8'h5A});
        check("path ais", {9'h000, path_ais}, 10'h001);
        rdc(STATUS_ADDR, 8'h02);
        wr(STATUS_ADDR, 8'h02);
        rdc(STATUS_ADDR, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(ICTL2_ADDR, 8'h20 | (c[1] ? 8'h08 : 8'h00));
            tx(c[0], ~c[0], 8'hA5);
            get({8'h00, c[0] ^ c[1], ~c[0] ^ c[1]});
        end
        wr(ICTL2_ADDR, 8'h10);
        p0 = lcv_n;
        tx(1'h1, 1'h1, 8'h00);
        tx(1'h1, 1'h0, 8'h00);
        tx(1'h0, 1'h1, 8'h00);
        get({8'h00, 2'h2});
        get({8'h00, 2'h2});
        get({8'h00, 2'h0});
        check("lcv events", 10'(lcv_n - p0), 10'h002);
        rdc(LCV_COUNT_ADDR, 8'h02);
        wr(ICTL2_ADDR, 8'h00);
        hold_neg_low = 1'h1;
        tx(1'h1, 1'h1, 8'h00);
        get({8'h00, 2'h2});
        hold_neg_low = 1'h0;
        // reserved mode code acts as sts-1, so a high negative pin is still ignored
        wr(ICTL2_ADDR, 8'h30);
        tx(1'h1, 1'h1, 8'h00);
        get({8'h00, 2'h2});
        // ready held low: 32 buffered plus the output word, the last is refused
        wr(ICTL2_ADDR, 8'h20);
        rx_ready <= 1'h0;
        for (int k = 0; k < 34; k++) begin
            tx(k[0], k[1], 8'h00);
        end
        rdc(STATUS_ADDR, 8'h04);
        rx_ready <= 1'h1;
        for (int k = 0; k < 33; k++) begin
            get({8'h00, k[0], k[1]});
        end
        repeat (4) @(posedge clk_sys);
        #1;
        check("rx valid", {9'h000, rx_valid}, 10'h000);
        print_verdict();
    end
endmodule // tb_top
